// >>> tb_top.sv
// Testbench for the limit, scratch and single-conversion register group.
// Assumes tlso_host drives the port and the checker is bound to the design.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk, rst_n, sleep, stby, wr, rd, hit, busy, start, upd, h;
	logic [7:0] addr, wdata, rdata, d, lcrit, hyst;
	logic [23:0] lli, rcrit;
	logic [32:0] low;
	logic [7:0] val [11];
	logic [7:0] adrs [11] = '{8'h0f, 8'h11, 8'h12, 8'h14, 8'h18, 8'h19, 8'h1a, 8'h20, 8'h21, 8'h2f, 8'h30};
	int error_cnt = 0;
	int check_count = 0;
	int n;
	tlso_host u_tlso_host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata),
		.hit_i(hit));
	tlso_regs u_tlso_regs (.REF_CLK_I(clk), .ARST_N_I(rst_n), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_HIT_O(hit), .SLEEP_I(sleep), .STANDBY_SEL_I(stby),
		.LOW_LIMIT_INTEGER_I(lli), .BUSY_O(busy), .CONV_START_O(start), .RESULTS_UPDATE_O(upd), .LOW_LIMIT_O(low),
		.REMOTE_CRITICAL_LIMIT_O(rcrit), .LOCAL_CRITICAL_LIMIT_O(lcrit), .CRITICAL_HYSTERESIS_O(hyst));
	// Limits and hysteresis come up nonzero, all else clears
	function automatic logic [7:0] rst_val(input logic [7:0] a);
		if (a inside {8'h19, 8'h1a, 8'h20, 8'h30}) return 8'h55;
		return (a == 8'h21) ? 8'h0a : 8'h00;
	endfunction
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	initial begin
		rst_n = 1'b0;
		sleep = 1'b1;
		stby = 1'b1;
		lli = 24'h0;
		d = 8'($urandom(32'h868a_16f4));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// Reset value, then a write and back-to-back readback; all ones hits a read-only byte
		foreach (adrs[i]) begin
			u_tlso_host.rd(adrs[i], d, h);
			chk(33'({h, d}), 33'({1'b1, rst_val(adrs[i])}));
			val[i] = (i == 3) ? 8'hff : 8'($urandom);
			u_tlso_host.wr(adrs[i], val[i]);
			u_tlso_host.rd(adrs[i], d, h);
			chk(33'(d), 33'((adrs[i] inside {8'h14, 8'h18, 8'h2f}) ? 8'h00 : val[i]));
		end
		chk(33'(rcrit), 33'({val[10], val[6], val[5]}));
		chk(33'({lcrit, hyst}), 33'({val[7], val[8]}));
		u_tlso_host.rd(8'h13, d, h);
		chk(33'({h, d}), 33'h0_0000_0000);
		// Integer bytes with an all-ones corner; eighths stay zero
		for (int k = 0; k < 4; k++) begin
			lli <= (k == 0) ? 24'hff_ffff : 24'($urandom);
			repeat (3) @(posedge clk);
			chk(low, {lli[23:16], 3'h0, lli[15:8], 3'h0, lli[7:0], 3'h0});
		end
		// Active, sleep, standby in turn; only standby may start
		for (int m = 0; m < 3; m++) begin
			sleep <= (m == 1);
			stby <= (m != 0);
			@(posedge clk);
			u_tlso_host.wr(8'h0f, 8'($urandom));
			@(negedge clk);
			chk(33'(start), 33'(m == 2));
			@(posedge clk);
		end
		u_tlso_host.wr(8'h0f, 8'h00);
		@(negedge clk);
		chk(33'({start, busy}), 33'(2'b01));
		n = 0;
		while (upd !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(33'({upd, busy}), 33'(2'b10));
		// Store pulse lands one conversion length plus one cycle after the start, one cycle short of a conversion length after the refused write
		chk(33'(n), 33'(tlso_pkg::CONV_CYCLES) - 33'h0_0000_0001);
		n = 0;
		repeat (40) begin
			@(negedge clk);
			if (start !== 1'b0) n++;
		end
		chk(33'(n), 33'h0_0000_0000);
		final_report();
	end
endmodule
`default_nettype wire

// >>> tlso_conv.sv
// Single-conversion sequencer: runs one conversion then stops.
// Assumes start is a one-cycle pulse already qualified by mode and busy.
`timescale 1ns/1ns
`default_nettype none
module tlso_conv (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	output logic busy_o,
	output logic done_o
);
	tlso_pkg::tlso_conv_e state_r;
	logic [7:0] cnt_r;
	// Sequencer; returns to idle with no restart
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= tlso_pkg::CV_IDLE;
			cnt_r <= 8'h00;
		end else begin
			case (state_r)
				tlso_pkg::CV_IDLE: begin
					if (start_i) begin
						state_r <= tlso_pkg::CV_RUN;
						cnt_r <= 8'h00;
					end
				end
				tlso_pkg::CV_RUN: begin
					cnt_r <= cnt_r + 8'h01;
					if (cnt_r == tlso_pkg::CONV_CYCLES - 8'h01) begin
						state_r <= tlso_pkg::CV_STORE;
					end
				end
				default: begin
					state_r <= tlso_pkg::CV_IDLE;
				end
			endcase
		end
	end
	assign busy_o = (state_r != tlso_pkg::CV_IDLE);
	assign done_o = (state_r == tlso_pkg::CV_STORE);
endmodule
`default_nettype wire

// >>> tlso_host.sv
// Host model of the byte register port, one access at a time.
// Assumes its tasks are entered at a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module tlso_host (
	// Clock
	input wire logic clk_i,
	// Requests
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	// Answers
	input wire logic [7:0] rdata_i,
	input wire logic hit_i
);
	// Idle port at time zero
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// Data flips after the strobe so a stale byte is never mistaken for a write
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= v;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~v;
	endtask
	// Answer is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic h);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		v = rdata_i;
		h = hit_i;
	endtask
endmodule
`default_nettype wire

// >>> tlso_mode.sv
// Power-mode selection from the sleep and run/standby control bits.
// Assumes both bits come from the configuration logic outside this group.
`timescale 1ns/1ns
`default_nettype none
module tlso_mode (
	input wire logic sleep_i,
	input wire logic standby_sel_i,
	output var tlso_pkg::tlso_pmode_e mode_o
);
	// Sleep overrides run/standby select
	always_comb begin
		if (sleep_i) begin
			mode_o = tlso_pkg::PM_SLEEP;
		end else if (standby_sel_i) begin
			mode_o = tlso_pkg::PM_STANDBY;
		end else begin
			mode_o = tlso_pkg::PM_ACTIVE;
		end
	end
endmodule
`default_nettype wire

// >>> tlso_pkg.sv
// Package for the limit, scratch and single-conversion register group.
// Assumes a simple synchronous byte-wide register port driven by the serial bus front end.
package tlso_pkg;
	// ***************************************************************
	// Register offsets
	// ***************************************************************
	localparam logic [7:0] ADDR_TRIGGER = 8'h0F;
	localparam logic [7:0] ADDR_SCRATCH1 = 8'h11;
	localparam logic [7:0] ADDR_SCRATCH2 = 8'h12;
	localparam logic [7:0] ADDR_FRAC1 = 8'h14;
	localparam logic [7:0] ADDR_FRAC2 = 8'h18;
	localparam logic [7:0] ADDR_FRAC3 = 8'h2F;
	localparam logic [7:0] ADDR_CRIT1 = 8'h19;
	localparam logic [7:0] ADDR_CRIT2 = 8'h1A;
	localparam logic [7:0] ADDR_CRIT3 = 8'h30;
	localparam logic [7:0] ADDR_LCRIT = 8'h20;
	localparam logic [7:0] ADDR_HYST = 8'h21;
	// ***************************************************************
	// Fields and reset values
	// ***************************************************************
	localparam int FRAC_MSB = 7;
	localparam int FRAC_LSB = 5;
	localparam int FRAC_W = 3;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CRIT = 8'h55;
	localparam logic [7:0] RST_HYST = 8'h0A;
	localparam int NUM_REMOTE = 3;
	// Conversion length in internal clock cycles
	localparam logic [7:0] CONV_CYCLES = 8'h10;
	// ***************************************************************
	// Types
	// ***************************************************************
	typedef enum logic [1:0] {PM_ACTIVE, PM_STANDBY, PM_SLEEP} tlso_pmode_e;
	typedef enum logic [1:0] {CV_IDLE, CV_RUN, CV_STORE} tlso_conv_e;
	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tlso_req_s;
	// Effective low limit: integer degrees plus eighths
	typedef struct packed {
		logic [7:0] whole;
		logic [2:0] eighths;
	} tlso_limit_s;
endpackage

// >>> tlso_regs.sv
// Limit, scratch and single-conversion register group of the temperature monitor.
// Assumes a synchronous byte register port from the serial bus front end, one access per cycle.
`timescale 1ns/1ns
`default_nettype none
module tlso_regs (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	// Register port
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	output logic [7:0] REG_RDATA_O,
	output logic REG_HIT_O,
	// Mode control and low-limit integers
	input wire logic SLEEP_I,
	input wire logic STANDBY_SEL_I,
	input wire logic [23:0] LOW_LIMIT_INTEGER_I,
	// Status and limits
	output logic BUSY_O,
	output logic CONV_START_O,
	output logic RESULTS_UPDATE_O,
	output logic [32:0] LOW_LIMIT_O,
	output logic [23:0] REMOTE_CRITICAL_LIMIT_O,
	output logic [7:0] LOCAL_CRITICAL_LIMIT_O,
	output logic [7:0] CRITICAL_HYSTERESIS_O
);
	// ***************************************************************
	// Storage
	// ***************************************************************
	tlso_pkg::tlso_req_s req;
	logic [tlso_pkg::FRAC_W-1:0] frac_r [tlso_pkg::NUM_REMOTE];
	logic [7:0] crit_r [tlso_pkg::NUM_REMOTE];
	logic [7:0] scratch1_r;
	logic [7:0] scratch2_r;
	logic [7:0] lcrit_r;
	logic [7:0] hyst_r;
	logic [7:0] trig_r;
	logic [7:0] rdata_nxt;
	logic hit_nxt;
	logic trig_wr;
	logic start;
	logic conv_busy;
	logic conv_done;
	tlso_pkg::tlso_pmode_e mode;

	// Bundle the port into one request
	assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};

	// ***************************************************************
	// Mode and conversion
	// ***************************************************************
	tlso_mode u_mode (
		.sleep_i(SLEEP_I),
		.standby_sel_i(STANDBY_SEL_I),
		.mode_o(mode)
	);

	// Trigger only from standby and only when idle; other trigger writes only store the byte
	assign trig_wr = req.wr && (req.addr == tlso_pkg::ADDR_TRIGGER);
	assign start = trig_wr && (mode == tlso_pkg::PM_STANDBY) && !conv_busy;

	tlso_conv u_conv (
		.clk_i(REF_CLK_I),
		.rst_n_i(ARST_N_I),
		.start_i(start),
		.busy_o(conv_busy),
		.done_o(conv_done)
	);

	// ***************************************************************
	// Register writes
	// ***************************************************************
	// Per-channel fraction and critical limits
	genvar g;
	generate
		for (g = 0; g < tlso_pkg::NUM_REMOTE; g++) begin : g_ch
			localparam logic [7:0] CA = (g == 0) ? tlso_pkg::ADDR_CRIT1 :
				(g == 1) ? tlso_pkg::ADDR_CRIT2 : tlso_pkg::ADDR_CRIT3;
			// Eighths are read-only to the host, so they keep their power-on zero
			// A flop per channel leaves room for a measurement-side loader later
			always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					frac_r[g] <= tlso_pkg::RST_ZERO[tlso_pkg::FRAC_W-1:0];
				end else begin
					frac_r[g] <= frac_r[g];
				end
			end
			always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					crit_r[g] <= tlso_pkg::RST_CRIT;
				end else if (req.wr && req.addr == CA) begin
					crit_r[g] <= req.wdata;
				end
			end
			// Effective limit: integer plus eighths, registered
			always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					LOW_LIMIT_O[g*11 +: 11] <= 11'h000;
				end else begin
					LOW_LIMIT_O[g*11 +: 11] <= {LOW_LIMIT_INTEGER_I[g*8 +: 8], frac_r[g]};
				end
			end
			always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
				if (!ARST_N_I) begin
					REMOTE_CRITICAL_LIMIT_O[g*8 +: 8] <= tlso_pkg::RST_CRIT;
				end else begin
					REMOTE_CRITICAL_LIMIT_O[g*8 +: 8] <= crit_r[g];
				end
			end
		end
	endgenerate

	// Scratch bytes steer nothing
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			scratch1_r <= tlso_pkg::RST_ZERO;
			scratch2_r <= tlso_pkg::RST_ZERO;
		end else begin
			if (req.wr && req.addr == tlso_pkg::ADDR_SCRATCH1) begin
				scratch1_r <= req.wdata;
			end
			if (req.wr && req.addr == tlso_pkg::ADDR_SCRATCH2) begin
				scratch2_r <= req.wdata;
			end
		end
	end

	// Local critical limit, hysteresis and the stored trigger byte
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			lcrit_r <= tlso_pkg::RST_CRIT;
			hyst_r <= tlso_pkg::RST_HYST;
			trig_r <= tlso_pkg::RST_ZERO;
		end else begin
			if (req.wr && req.addr == tlso_pkg::ADDR_LCRIT) begin
				lcrit_r <= req.wdata;
			end
			if (req.wr && req.addr == tlso_pkg::ADDR_HYST) begin
				hyst_r <= req.wdata;
			end
			if (trig_wr) begin
				trig_r <= req.wdata;
			end
		end
	end

	// ***************************************************************
	// Read path
	// ***************************************************************
	// Unmapped addresses read zero with no hit
	always_comb begin
		rdata_nxt = tlso_pkg::RST_ZERO;
		hit_nxt = 1'b1;
		if (req.addr == tlso_pkg::ADDR_TRIGGER) begin
			rdata_nxt = trig_r;
		end else if (req.addr == tlso_pkg::ADDR_SCRATCH1) begin
			rdata_nxt = scratch1_r;
		end else if (req.addr == tlso_pkg::ADDR_SCRATCH2) begin
			rdata_nxt = scratch2_r;
		end else if (req.addr == tlso_pkg::ADDR_FRAC1) begin
			rdata_nxt = {frac_r[0], 5'b0_0000};
		end else if (req.addr == tlso_pkg::ADDR_FRAC2) begin
			rdata_nxt = {frac_r[1], 5'b0_0000};
		end else if (req.addr == tlso_pkg::ADDR_FRAC3) begin
			rdata_nxt = {frac_r[2], 5'b0_0000};
		end else if (req.addr == tlso_pkg::ADDR_CRIT1) begin
			rdata_nxt = crit_r[0];
		end else if (req.addr == tlso_pkg::ADDR_CRIT2) begin
			rdata_nxt = crit_r[1];
		end else if (req.addr == tlso_pkg::ADDR_CRIT3) begin
			rdata_nxt = crit_r[2];
		end else if (req.addr == tlso_pkg::ADDR_LCRIT) begin
			rdata_nxt = lcrit_r;
		end else if (req.addr == tlso_pkg::ADDR_HYST) begin
			rdata_nxt = hyst_r;
		end else begin
			hit_nxt = 1'b0;
		end
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			REG_RDATA_O <= 8'h00;
			REG_HIT_O <= 1'b0;
		end else if (req.rd) begin
			REG_RDATA_O <= rdata_nxt;
			REG_HIT_O <= hit_nxt;
		end
	end

	// ***************************************************************
	// Status outputs
	// ***************************************************************
	// Busy mirrors the sequencer, with start folded in so it rises with the write
	always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			BUSY_O <= 1'b0;
			CONV_START_O <= 1'b0;
			RESULTS_UPDATE_O <= 1'b0;
			LOCAL_CRITICAL_LIMIT_O <= tlso_pkg::RST_CRIT;
			CRITICAL_HYSTERESIS_O <= tlso_pkg::RST_HYST;
		end else begin
			BUSY_O <= (conv_busy && !conv_done) || start;
			CONV_START_O <= start;
			RESULTS_UPDATE_O <= conv_done;
			LOCAL_CRITICAL_LIMIT_O <= lcrit_r;
			CRITICAL_HYSTERESIS_O <= hyst_r;
		end
	end
endmodule
`default_nettype wire

// >>> tlso_regs_sva.sv
// Checker for the limit, scratch and single-conversion register group.
// Assumes it is bound to tlso_regs and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module tlso_regs_sva (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic ARST_N_I,
	// Register port
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic [7:0] REG_RDATA_O,
	input wire logic REG_HIT_O,
	// Mode and conversion
	input wire logic SLEEP_I,
	input wire logic STANDBY_SEL_I,
	input wire logic BUSY_O,
	input wire logic CONV_START_O,
	input wire logic RESULTS_UPDATE_O,
	// Low limits
	input wire logic [23:0] LOW_LIMIT_INTEGER_I,
	input wire logic [32:0] LOW_LIMIT_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	logic trig;
	// Host write to the trigger byte, whatever the data
	assign trig = REG_WR_I && REG_ADDR_I == 8'h0f;
	property p_start; trig && STANDBY_SEL_I && !SLEEP_I && !BUSY_O |=> CONV_START_O && BUSY_O; endproperty
	a_start: assert property (p_start) else $error("standby trigger did not start");
	property p_active; trig && !STANDBY_SEL_I && !SLEEP_I |=> !CONV_START_O; endproperty
	a_active: assert property (p_active) else $error("trigger acted while active");
	property p_sleep; trig && SLEEP_I |=> !CONV_START_O; endproperty
	a_sleep: assert property (p_sleep) else $error("trigger acted while asleep");
	property p_busy; trig && BUSY_O |=> !CONV_START_O; endproperty
	a_busy: assert property (p_busy) else $error("trigger acted while busy");
	// Busy holds for the start cycle plus the 16-cycle run, then drops with the store pulse
	property p_len; CONV_START_O |-> BUSY_O [*8] ##1 BUSY_O [*8] ##1 BUSY_O ##1 RESULTS_UPDATE_O && !BUSY_O;
	endproperty
	a_len: assert property (p_len) else $error("conversion length or busy wrong");
	property p_done; RESULTS_UPDATE_O && !trig |=> !CONV_START_O && !BUSY_O; endproperty
	a_done: assert property (p_done) else $error("conversion restarted by itself");
	property p_cause; CONV_START_O |-> $past(trig); endproperty
	a_cause: assert property (p_cause) else $error("start without trigger write");
	property p_frac; REG_RD_I && REG_ADDR_I inside {8'h14, 8'h18, 8'h2f} |=> REG_RDATA_O == 8'h00 && REG_HIT_O; endproperty
	a_frac: assert property (p_frac) else $error("fraction byte not zero");
	property p_scr; REG_WR_I && REG_ADDR_I == 8'h11 ##1 REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h11
		|=> REG_RDATA_O == $past(REG_WDATA_I, 2); endproperty
	a_scr: assert property (p_scr) else $error("scratch readback wrong");
	property p_low; $stable(LOW_LIMIT_INTEGER_I) [*2] |-> LOW_LIMIT_O == {LOW_LIMIT_INTEGER_I[23:16], 3'h0,
		LOW_LIMIT_INTEGER_I[15:8], 3'h0, LOW_LIMIT_INTEGER_I[7:0], 3'h0}; endproperty
	a_low: assert property (p_low) else $error("effective low limit wrong");
	c_start: cover property (CONV_START_O);
	c_upd: cover property (RESULTS_UPDATE_O);
	c_busy: cover property (trig && BUSY_O);
endmodule
bind tlso_regs tlso_regs_sva u_tlso_regs_sva (
	.REF_CLK_I(REF_CLK_I),
	.ARST_N_I(ARST_N_I),
	.REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I),
	.REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I),
	.REG_RDATA_O(REG_RDATA_O),
	.REG_HIT_O(REG_HIT_O),
	.SLEEP_I(SLEEP_I),
	.STANDBY_SEL_I(STANDBY_SEL_I),
	.BUSY_O(BUSY_O),
	.CONV_START_O(CONV_START_O),
	.RESULTS_UPDATE_O(RESULTS_UPDATE_O),
	.LOW_LIMIT_INTEGER_I(LOW_LIMIT_INTEGER_I),
	.LOW_LIMIT_O(LOW_LIMIT_O)
);
`default_nettype wire
